// ===== shared/deac_pkg.sv
package deac_pkg;
	localparam logic [5:0] OFF_ADDR_LO = 6'h00;
	localparam logic [5:0] OFF_ADDR_HI = 6'h04;
	localparam logic [5:0] OFF_DATA = 6'h08;
	localparam logic [5:0] OFF_CTRL = 6'h0C;
	localparam logic [5:0] OFF_UNLOCK = 6'h10;
	localparam logic [5:0] OFF_STATUS = 6'h14;
	localparam int B_PROG = 7;
	localparam int B_CFG = 6;
	localparam int B_ERR = 3;
	localparam int B_WRITE_ENABLE_BIT = 2;
	localparam int B_WR = 1;
	localparam int B_RD = 0;
	localparam int B_DONE = 0;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [7:0] CTRL_WMASK = 8'hC4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int WRITE_TIME_NS = 4000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		DEAC_KEY_IDLE = 3'b001,
		DEAC_KEY_HALF = 3'b010,
		DEAC_KEY_OPEN = 3'b100
	} deac_key_t;
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] data;
	} deac_wr_t;
endpackage

// ===== core/deac_array.sv
`timescale 1ns/1ps
module deac_array #(
	parameter int AW = 10,
	parameter int WRITE_CNT = deac_pkg::WRITE_CYCLES
) (
	input wire logic clk_in, // clock
	input wire logic rstn_in, // sync reset, active low
	input wire logic rd_in, // read strobe
	input wire logic wr_in, // write start strobe
	input wire logic [AW-1:0] addr_in, // byte address
	input wire logic [7:0] wdata_in, // byte to store
	output logic [7:0] rdata_out, // byte read
	output logic busy_out, // write cycle running
	output logic done_out // one-cycle pulse at write end
);
	logic [7:0] mem [0:(1<<AW)-1];
	logic [31:0] cnt_reg;
	logic [AW-1:0] waddr_reg;
	logic [7:0] wdata_reg;

	always_ff @(posedge clk_in) begin
		if (rd_in) begin
			rdata_out <= mem[addr_in];
		end
	end

	// the array cell is written only at the end of the timed cycle
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cnt_reg <= 32'h0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= 8'h00;
		end else begin
			done_out <= 1'b0;
			if (wr_in && !busy_out) begin
				busy_out <= 1'b1;
				cnt_reg <= 32'(WRITE_CNT - 1);
				waddr_reg <= addr_in;
				wdata_reg <= wdata_in;
			end else if (busy_out) begin
				if (cnt_reg == 32'h0) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
					mem[waddr_reg] <= wdata_reg;
				end else begin
					cnt_reg <= cnt_reg - 32'h1;
				end
			end
		end
	end
endmodule

// ===== core/deac_top.sv
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module deac_top #(
	parameter int AW = 10,
	parameter int WRITE_CNT = deac_pkg::WRITE_CYCLES
) (
	input wire logic clk_in, // 200 MHz clock
	input wire logic rstn_in, // sync reset, active low
	input wire logic rst_cause_in, // high when reset is master-clear or watchdog
	input wire logic [5:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [5:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	output logic write_busy_out // write cycle in progress
);
	logic aw_got_reg;
	logic w_got_reg;
	deac_pkg::deac_wr_t wr_reg;
	logic [7:0] addr_lo_reg;
	logic [7:0] addr_hi_reg;
	logic [7:0] data_reg;
	logic prog_sel_reg;
	logic cfg_sel_reg;
	logic err_reg;
	logic write_enable_bit_reg;
	logic wr_bit_reg;
	logic rd_pulse_reg;
	logic done_flag_reg;
	logic busy_reg;
	deac_pkg::deac_key_t key_reg;
	logic [7:0] arr_rdata;
	logic arr_busy;
	logic arr_done;
	logic wr_fire;
	logic lane0;
	logic [7:0] wbyte;
	logic frozen;
	logic start_wr;
	logic start_rd;
	logic rd_tail_reg;

	function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
		return a == off;
	endfunction

	////////////////////////////////////////////////////////////////////
	// axi write channel: address and data taken in either order
	assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
	assign lane0 = wr_reg.addr[1:0] == 2'h0;
	assign wbyte = wr_reg.data;
	assign frozen = busy_reg || wr_bit_reg;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			wr_reg <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= deac_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_got_reg && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_got_reg && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				wr_reg.addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				wr_reg.data <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= lane0 && wr_reg.addr <= deac_pkg::OFF_STATUS ?
					deac_pkg::RESP_OKAY : deac_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// unlock tracking: no storage, only a sequence state
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			key_reg <= deac_pkg::DEAC_KEY_IDLE;
		end else if (wr_fire) begin
			unique case (key_reg)
				deac_pkg::DEAC_KEY_IDLE: begin
					key_reg <= hit(wr_reg.addr, deac_pkg::OFF_UNLOCK) &&
						wbyte == deac_pkg::KEY_FIRST ?
						deac_pkg::DEAC_KEY_HALF : deac_pkg::DEAC_KEY_IDLE;
				end
				deac_pkg::DEAC_KEY_HALF: begin
					key_reg <= hit(wr_reg.addr, deac_pkg::OFF_UNLOCK) &&
						wbyte == deac_pkg::KEY_SECOND ?
						deac_pkg::DEAC_KEY_OPEN : deac_pkg::DEAC_KEY_IDLE;
				end
				deac_pkg::DEAC_KEY_OPEN: begin
					key_reg <= deac_pkg::DEAC_KEY_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// control register
	assign start_wr = wr_fire && hit(wr_reg.addr, deac_pkg::OFF_CTRL) && !frozen &&
		wbyte[deac_pkg::B_WR] && write_enable_bit_reg &&
		key_reg == deac_pkg::DEAC_KEY_OPEN &&
		!wbyte[deac_pkg::B_PROG] && !wbyte[deac_pkg::B_CFG];
	assign start_rd = wr_fire && hit(wr_reg.addr, deac_pkg::OFF_CTRL) && !frozen &&
		wbyte[deac_pkg::B_RD] && !wbyte[deac_pkg::B_PROG];

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			prog_sel_reg <= 1'b0;
			cfg_sel_reg <= 1'b0;
			write_enable_bit_reg <= 1'b0;
			rd_pulse_reg <= 1'b0;
			rd_tail_reg <= 1'b0;
		end else begin
			rd_pulse_reg <= start_rd;
			rd_tail_reg <= rd_pulse_reg;
			if (wr_fire && hit(wr_reg.addr, deac_pkg::OFF_CTRL) && !frozen) begin
				prog_sel_reg <= wbyte[deac_pkg::B_PROG];
				cfg_sel_reg <= wbyte[deac_pkg::B_CFG];
				write_enable_bit_reg <= wbyte[deac_pkg::B_WRITE_ENABLE_BIT];
			end
		end
	end

	// write bit: software sets only, hardware clears at completion
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			wr_bit_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			if (start_wr) begin
				wr_bit_reg <= 1'b1;
				busy_reg <= 1'b1;
			end else if (arr_done) begin
				wr_bit_reg <= 1'b0;
				busy_reg <= 1'b0;
			end
		end
	end

	// error flag is set by a master-clear or watchdog reset that cut a write short, and kept by one
	// a power-on kind of reset clears it, so the flag never starts unknown
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			err_reg <= rst_cause_in && (busy_reg || err_reg);
		end else if (start_wr) begin
			err_reg <= 1'b0;
		end
	end

	// done flag: set wins over a same-cycle software clear
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			done_flag_reg <= 1'b0;
		end else if (arr_done) begin
			done_flag_reg <= 1'b1;
		end else if (wr_fire && hit(wr_reg.addr, deac_pkg::OFF_STATUS) &&
			!wbyte[deac_pkg::B_DONE]) begin
			done_flag_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// address and data registers
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			addr_lo_reg <= 8'h00;
			addr_hi_reg <= 8'h00;
			data_reg <= 8'h00;
		end else begin
			if (wr_fire && !frozen && hit(wr_reg.addr, deac_pkg::OFF_ADDR_LO)) begin
				addr_lo_reg <= wbyte;
			end
			if (wr_fire && !frozen && hit(wr_reg.addr, deac_pkg::OFF_ADDR_HI)) begin
				addr_hi_reg <= wbyte;
			end
			if (rd_tail_reg) begin
				data_reg <= arr_rdata;
			end else if (wr_fire && !frozen && hit(wr_reg.addr, deac_pkg::OFF_DATA)) begin
				data_reg <= wbyte;
			end
		end
	end

	deac_array #(
		.AW(AW),
		.WRITE_CNT(WRITE_CNT)
	) u_array (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.rd_in(rd_pulse_reg),
		.wr_in(start_wr),
		.addr_in(AW'({addr_hi_reg, addr_lo_reg})),
		.wdata_in(data_reg),
		.rdata_out(arr_rdata),
		.busy_out(arr_busy),
		.done_out(arr_done)
	);

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			write_busy_out <= 1'b0;
		end else begin
			write_busy_out <= arr_busy;
		end
	end

	////////////////////////////////////////////////////////////////////
	// axi read channel
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= deac_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= deac_pkg::RESP_OKAY;
				unique case (s_axi_araddr)
					deac_pkg::OFF_ADDR_LO: s_axi_rdata <= {24'h0, addr_lo_reg};
					deac_pkg::OFF_ADDR_HI: s_axi_rdata <= {24'h0, addr_hi_reg};
					deac_pkg::OFF_DATA: s_axi_rdata <= {24'h0, data_reg};
					deac_pkg::OFF_CTRL: s_axi_rdata <= {24'h0, prog_sel_reg, cfg_sel_reg,
						2'h0, err_reg, write_enable_bit_reg, wr_bit_reg, rd_pulse_reg};
					deac_pkg::OFF_STATUS: s_axi_rdata <= {31'h0, done_flag_reg};
					default: begin
						// unlock port reads zero; unmapped answers an error
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= hit(s_axi_araddr, deac_pkg::OFF_UNLOCK) ?
							deac_pkg::RESP_OKAY : deac_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	sequence s_key_open;
		key_reg == deac_pkg::DEAC_KEY_OPEN;
	endsequence

	a_wr_needs_key: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$rose(wr_bit_reg) |-> $past(key_reg == deac_pkg::DEAC_KEY_OPEN && write_enable_bit_reg))
		else $error("write started without unlock");
	a_write_enable_bit_kept: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(write_enable_bit_reg) |-> $past(wr_fire && hit(wr_reg.addr, deac_pkg::OFF_CTRL)))
		else $error("write enable cleared by hardware");
	a_done_sets: assert property (@(posedge clk_in) disable iff (!rstn_in)
		arr_done |=> done_flag_reg && !wr_bit_reg)
		else $error("completion not flagged");
	a_done_sticky: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(done_flag_reg) |-> $past(wr_fire && hit(wr_reg.addr, deac_pkg::OFF_STATUS)))
		else $error("done flag cleared by hardware");
	a_rd_one: assert property (@(posedge clk_in) disable iff (!rstn_in)
		rd_pulse_reg |=> !rd_pulse_reg ##1 data_reg == $past(arr_rdata))
		else $error("read bit not self-clearing");
	a_rd_prog: assert property (@(posedge clk_in) disable iff (!rstn_in)
		rd_pulse_reg |-> !prog_sel_reg)
		else $error("read with program space");
	a_frozen_addr: assert property (@(posedge clk_in) disable iff (!rstn_in)
		busy_reg && $past(busy_reg) |-> $stable(addr_lo_reg) && $stable(data_reg))
		else $error("registers changed during write");
	a_key_then_idle: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_key_open ##0 wr_fire |=> key_reg == deac_pkg::DEAC_KEY_IDLE)
		else $error("unlock did not return idle");
	a_wr_with_en: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wr_fire && hit(wr_reg.addr, deac_pkg::OFF_CTRL) && !frozen && !write_enable_bit_reg |=>
		!wr_bit_reg)
		else $error("write and enable in one access");
endmodule

// ===== tb/deac_top_tb.sv
`timescale 1ns/1ps
module deac_top_tb;
	// long enough that the frozen-register checks land inside the write cycle
	localparam int WCNT = 40;
	localparam logic [5:0] CTRL = deac_pkg::OFF_CTRL;
	localparam logic [5:0] DATA = deac_pkg::OFF_DATA;
	localparam logic [5:0] UNLK = deac_pkg::OFF_UNLOCK;
	localparam logic [5:0] STAT = deac_pkg::OFF_STATUS;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic rst_cause_in = 1'b0;
	logic [5:0] s_axi_awaddr = 6'h00;
	logic [5:0] s_axi_araddr = 6'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic write_busy_out;
	logic [1:0] s_axi_bresp, s_axi_rresp, bresp_q, rresp_q;
	logic [31:0] s_axi_rdata, rdat;
	logic [9:0] a;
	logic [7:0] v;
	int failures = 0;
	int total_checks = 0;
	int seed = 66696;

	always #2.5 clk_in = ~clk_in;

	deac_top #(.WRITE_CNT(WCNT)) u_dut (.clk_in, .rstn_in, .rst_cause_in, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.write_busy_out);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [31:0] ctrl_word(input logic err, input logic write_enable_bit, input logic wbit);
		return {24'h0, 4'h0, err, write_enable_bit, wbit, 1'b0};
	endfunction

	task automatic stop_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// both channels offered together, each dropped once taken
	task automatic wr(input logic [5:0] ad, input logic [7:0] d);
		bit aw, w;
		int n;
		aw = 0;
		w = 0;
		n = 0;
		@(posedge clk_in);
		s_axi_awaddr <= ad;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= 4'h1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (aw && w && s_axi_bvalid) break;
			if (!aw && s_axi_awready) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end while (n < 60);
		bresp_q = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 60) failures++;
	endtask

	task automatic rd(input logic [5:0] ad);
		int n;
		n = 0;
		@(posedge clk_in);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 60);
		rdat = s_axi_rdata;
		rresp_q = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 60) failures++;
	endtask

	task automatic reset_dut(input logic cause);
		@(posedge clk_in);
		rst_cause_in <= cause;
		rstn_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		rstn_in <= 1'b1;
		rst_cause_in <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask

	task automatic set_ad(input logic [9:0] ad, input logic [7:0] d);
		wr(deac_pkg::OFF_ADDR_LO, ad[7:0]);
		wr(deac_pkg::OFF_ADDR_HI, {6'h00, ad[9:8]});
		wr(DATA, d);
	endtask

	task automatic start_write(input logic [9:0] ad, input logic [7:0] d);
		set_ad(ad, d);
		wr(CTRL, 8'h04);
		wr(UNLK, deac_pkg::KEY_FIRST);
		wr(UNLK, deac_pkg::KEY_SECOND);
		wr(CTRL, 8'h06);
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		do begin
			rd(CTRL);
			n++;
		end while (rdat[1] !== 1'b0 && n < 40);
		if (n >= 40) failures++;
	endtask

	// a refused start must leave write bit and done flag low after a full write time
	task automatic no_start();
		repeat (WCNT + 4) @(posedge clk_in);
		rd(CTRL);
		check("write bit", {31'h0, rdat[1]}, 32'h0);
		rd(STAT);
		check("done flag", rdat, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		failures++;
		stop_test();
	end

	initial begin
		reset_dut(1'b0);
		rd(CTRL);
		check("control reset", rdat, ctrl_word(1'b0, 1'b0, 1'b0));
		rd(DATA);
		check("data reset", rdat, 32'h0);
		rd(6'h18);
		check("rresp unmapped", {30'h0, rresp_q}, {30'h0, deac_pkg::RESP_SLVERR});
		wr(6'h18, 8'h11);
		check("bresp unmapped", {30'h0, bresp_q}, {30'h0, deac_pkg::RESP_SLVERR});
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 10'h3FF : 10'($random(seed));
			v = (i == 1) ? 8'hFF : 8'($random(seed));
			start_write(a, v);
			rd(CTRL);
			check("write started", {31'h0, rdat[1]}, 32'h1);
			wr(DATA, ~v);
			check("bresp frozen", {30'h0, bresp_q}, {30'h0, deac_pkg::RESP_OKAY});
			wr(CTRL, 8'h00);
			rd(CTRL);
			check("control frozen", {29'h0, rdat[2:0] & 3'h6}, 32'h6);
			check("busy pin", {31'h0, write_busy_out}, 32'h1);
			wait_done();
			check("busy idle", {31'h0, write_busy_out}, 32'h0);
			check("enable kept", {31'h0, rdat[2]}, 32'h1);
			rd(STAT);
			check("done set", rdat, 32'h1);
			rd(STAT);
			check("done held", rdat, 32'h1);
			rd(DATA);
			check("data frozen", rdat, {24'h0, v});
			wr(STAT, 8'h00);
			rd(STAT);
			check("done cleared", rdat, 32'h0);
			set_ad(a, 8'h00);
			wr(CTRL, 8'h01);
			rd(DATA);
			check("read byte", rdat, {24'h0, v});
			check("rresp data", {30'h0, rresp_q}, {30'h0, deac_pkg::RESP_OKAY});
			rd(CTRL);
			check("read bit clear", {31'h0, rdat[0]}, 32'h0);
		end
		wr(CTRL, 8'h00);
		wr(UNLK, deac_pkg::KEY_FIRST);
		wr(UNLK, deac_pkg::KEY_SECOND);
		wr(CTRL, 8'h06);
		no_start();
		wr(CTRL, 8'h04);
		wr(UNLK, deac_pkg::KEY_SECOND);
		wr(UNLK, deac_pkg::KEY_FIRST);
		wr(CTRL, 8'h06);
		no_start();
		wr(UNLK, deac_pkg::KEY_FIRST);
		wr(DATA, 8'h3C);
		wr(UNLK, deac_pkg::KEY_SECOND);
		wr(CTRL, 8'h06);
		no_start();
		// program space selected: the read must not touch the data register
		wr(CTRL, 8'h81);
		repeat (2) @(posedge clk_in);
		rd(DATA);
		check("read refused", rdat, 32'h3C);
		start_write(10'h155, 8'hA5);
		reset_dut(1'b1);
		rd(CTRL);
		check("error flag", rdat, ctrl_word(1'b1, 1'b0, 1'b0));
		rd(deac_pkg::OFF_ADDR_LO);
		check("address cleared", rdat, 32'h0);
		rd(DATA);
		check("data cleared", rdat, 32'h0);
		stop_test();
	end
endmodule
